/* File: hdl/wdog_pkg.sv */
// Shared constants, carriers and state types for the windowed watchdog
package wdog_pkg;
    // Register byte offsets on the AXI4-Lite slave
    localparam logic [7:0]  SVC_ADDR        = 8'h00;
    localparam logic [7:0]  STAT_ADDR       = 8'h04;
    // Status register bit positions
    localparam int          STAT_FIRST_BIT  = 0;
    localparam int          STAT_WDDRV_BIT  = 1;
    localparam int          STAT_CMDRV_BIT  = 2;
    localparam int          STAT_PIN_BIT    = 3;
    localparam int          STAT_BOOT_BIT   = 4;
    localparam int          STAT_CNT_LSB    = 8;
    // Service register contents after reset and the fixed key
    localparam logic [1:0]  WIN_RST         = 2'h3;
    localparam logic        CM_RST          = 1'b1;
    localparam logic [4:0]  KEY_PATTERN     = 5'h0C;
    // Window limits in idle timer clocks
    localparam logic [16:0] LOWER_LIMIT     = 17'h00800;
    localparam logic [16:0] UPPER_BASE      = 17'h02000;
    // Fault pulse stretch after the pin is seen low, within 16 to 32 cycles
    localparam logic [5:0]  FAULT_HOLD_CYC  = 6'h18;
    // Clock monitor rejection threshold, between 200 us and 100 ms gaps
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          CM_REJECT_US    = 1000;
    localparam int          CM_REJECT_CYC   = CM_REJECT_US * 1000 / CLK_PERIOD_NS;
    // AXI responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_DECERR     = 2'h3;
    // Layout of the eight-bit service word
    typedef struct packed {
        logic [1:0] win;
        logic [4:0] key;
        logic       cm;
    } svc_t;
    // Fault pulse sequencer
    typedef enum logic [1:0] {
        F_IDLE,
        F_DRIVE,
        F_HOLD,
        F_RELEASE
    } fault_st_t;
endpackage

/* File: hdl/windowed_watchdog.sv */
// Windowed watchdog with clock monitor and open-drain fault pin
// What this block does
// - Service before 2048 idle clocks is early
// - Top two bits pick 8k-64k upper limit
// - Key field 01100 checked on each service write while enabled and outside a fault
// - Bit 0 enables the clock monitor
// - Active only while option bit is zero
// - Chip reset holds both detectors inactive
// - Reset arms maximum window, monitor enabled
// - First keyed service locks window and monitor
// - Later mismatch in any field is error
// - Fully matching service restarts the window
// - Service inside lower limit is error
// - Boot entry services, suppresses lower check
// - After boot return, early service accepted
// - Fault pin active low, open drain
// - Drive low, hold 16-32 cycles after low
// - Window restarts when pin returns high
// - Service during fault is ignored
// - Pin low at power-up times out, releases
// - Monitor holds pin low while clock slow
// - Reject below 10 Hz, never at 5 kHz
// - Window counted in idle timer clocks
// - Key reads back as zeros
// - Watchdog paused in halt/idle, monitor not
// - Leaving idle gives a hardware service
`timescale 1ns/1ps
module windowed_watchdog
    import wdog_pkg::*;
#(
    parameter int CM_REJECT = CM_REJECT_CYC
) (
    // Clock and synchronous reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write channels
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready_q,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready_q,
    output logic [1:0]       bresp_q,
    output logic             bvalid_q,
    input  wire logic        bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready_q,
    output logic [31:0]      rdata_q,
    output logic [1:0]       rresp_q,
    output logic             rvalid_q,
    input  wire logic        rready,
    // Core status inputs
    input  wire logic        wd_option_n,
    input  wire logic        idle_timer,
    input  wire logic        instr_tick,
    input  wire logic        halt_mode,
    input  wire logic        idle_mode,
    input  wire logic        boot_enter,
    input  wire logic        boot_exit,
    // Open-drain fault pin on port_g_bit1
    input  wire logic        wd_fault_pin_in,
    output logic             wd_fault_pin_out_q,
    output logic             wd_fault_pin_oe_q
);

    // Threshold must fit the gap counter and sit above one cycle
    if (CM_REJECT < 2 || CM_REJECT > 24'hFFFFFF) begin : g_bad_param
        $error("CM_REJECT out of range");
    end

    localparam logic [23:0] CM_LIM = 24'(CM_REJECT);

    // Upper limit for a window selection
    function automatic logic [16:0] upper_limit(input logic [1:0] sel);
        upper_limit = UPPER_BASE << sel;
    endfunction

    // Word-aligned match of a byte address
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] r);
        addr_hit = (a[7:2] == r[7:2]);
    endfunction

    // Bus bookkeeping
    logic        aw_got_q;    // Write address held
    logic        w_got_q;     // Write data held
    logic [7:0]  awaddr_q;    // Latched write address
    svc_t        wdata_q;     // Latched low byte of write data
    logic        wstrb0_q;    // Low byte lane strobe
    logic        aw_got_d;
    logic        w_got_d;
    logic        wr_go;       // Both halves present, response slot free
    logic        ar_hs;
    logic        rd_svc_q;    // Last read hit the service register

    // Watchdog state
    logic        wd_en;       // Option selects watchdog
    logic        first_q;     // Initial service done
    logic [1:0]  win_q;       // Locked window select
    logic        cm_en_q;     // Locked monitor enable
    logic [16:0] wcnt_q;      // Idle clocks since window restart
    logic        lower_chk_q; // Lower limit armed
    logic        boot_q;      // Executing boot code
    logic        idle_q;      // Idle mode delayed
    fault_st_t   fst_q;
    fault_st_t   fst_d;
    logic [5:0]  hold_q;      // Fault stretch counter

    // Clock monitor state
    logic [23:0] gap_q;       // Cycles since last instruction tick
    logic        cm_slow;
    logic        cm_drv_q;
    logic        cm_drv_d;
    logic [5:0]  cm_hold_q;

    // Service decode
    logic        svc_wr;
    logic        pin_low;
    logic        busy;
    logic        counting;
    logic        key_ok;
    logic        all_ok;
    logic        svc_err;
    logic        svc_ok;
    logic        timeout;
    logic        hw_svc;
    logic        restart;
    logic        wd_err;

    assign wd_en    = ~wd_option_n;
    assign aw_got_d = (aw_got_q | (awvalid & awready_q)) & ~wr_go;
    assign w_got_d  = (w_got_q | (wvalid & wready_q)) & ~wr_go;
    assign wr_go    = aw_got_q & w_got_q & ~bvalid_q;
    assign ar_hs    = arvalid & arready_q;
    assign svc_wr   = wr_go & addr_hit(awaddr_q, SVC_ADDR) & wstrb0_q;
    assign pin_low  = ~wd_fault_pin_in;
    // A low pin from any cause counts as an active fault
    assign busy     = (fst_q != F_IDLE) | pin_low;
    assign counting = wd_en & ~halt_mode & ~idle_mode & (fst_q == F_IDLE);
    assign key_ok   = (wdata_q.key == KEY_PATTERN);
    assign all_ok   = key_ok & (wdata_q.win == win_q) & (wdata_q.cm == cm_en_q);

    // Service verdict; the first service skips the lower check
    always_comb begin
        svc_err = 1'b0;
        svc_ok  = 1'b0;
        if (svc_wr && wd_en && !busy) begin
            if (!first_q) begin
                svc_ok  = key_ok;
                svc_err = ~key_ok;
            end else if (!all_ok) begin
                svc_err = 1'b1;
            end else if (lower_chk_q && !boot_q && wcnt_q < LOWER_LIMIT) begin
                svc_err = 1'b1;
            end else begin
                svc_ok  = 1'b1;
            end
        end
    end

    assign timeout = counting & (wcnt_q >= upper_limit(win_q));
    assign hw_svc  = boot_enter | boot_exit | (idle_q & ~idle_mode);
    assign restart = svc_ok | hw_svc
                   | ((fst_q == F_RELEASE) & wd_fault_pin_in);
    assign wd_err  = svc_err | timeout;

    // Write address and data capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= '0;
            wstrb0_q  <= 1'b0;
        end else begin
            aw_got_q  <= aw_got_d;
            w_got_q   <= w_got_d;
            awready_q <= ~aw_got_d;
            wready_q  <= ~w_got_d;
            if (awvalid && awready_q) begin
                awaddr_q <= awaddr;
            end
            if (wvalid && wready_q) begin
                wdata_q  <= wdata[7:0];
                wstrb0_q <= wstrb[0];
            end
        end
    end

    // Write response; unmapped addresses get a decode error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            if (addr_hit(awaddr_q, SVC_ADDR) || addr_hit(awaddr_q, STAT_ADDR)) begin
                bresp_q <= RESP_OKAY;
            end else begin
                bresp_q <= RESP_DECERR;
            end
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read channel, one read in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h00000000;
            rresp_q   <= RESP_OKAY;
            rd_svc_q  <= 1'b0;
        end else begin
            arready_q <= ~(ar_hs | (rvalid_q & ~rready));
            if (ar_hs) begin
                rvalid_q <= 1'b1;
                rresp_q  <= RESP_OKAY;
                rd_svc_q <= addr_hit(araddr, SVC_ADDR);
                rdata_q  <= 32'h00000000;
                if (addr_hit(araddr, SVC_ADDR)) begin
                    // Key never leaves the block
                    rdata_q[7:0] <= {win_q, 5'h00, cm_en_q};
                end else if (addr_hit(araddr, STAT_ADDR)) begin
                    rdata_q[STAT_FIRST_BIT] <= first_q;
                    rdata_q[STAT_WDDRV_BIT] <= (fst_q == F_DRIVE) | (fst_q == F_HOLD);
                    rdata_q[STAT_CMDRV_BIT] <= cm_drv_q;
                    rdata_q[STAT_PIN_BIT]   <= wd_fault_pin_in;
                    rdata_q[STAT_BOOT_BIT]  <= boot_q;
                    rdata_q[STAT_CNT_LSB +: 17] <= wcnt_q;
                end else begin
                    rresp_q <= RESP_DECERR;
                end
            end else if (rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Window and monitor choices, locked after the first good service
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            first_q <= 1'b0;
            win_q   <= WIN_RST;
            cm_en_q <= CM_RST;
        end else if (svc_ok && !first_q) begin
            first_q <= 1'b1;
            win_q   <= wdata_q.win;
            cm_en_q <= wdata_q.cm;
        end
    end

    // Lower check arming and boot tracking
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lower_chk_q <= 1'b0;
            boot_q      <= 1'b0;
            idle_q      <= 1'b0;
        end else begin
            idle_q <= idle_mode;
            if (boot_enter) begin
                boot_q <= 1'b1;
            end else if (boot_exit) begin
                boot_q <= 1'b0;
            end
            // Boot return leaves the next user service unchecked
            if (boot_exit) begin
                lower_chk_q <= 1'b0;
            end else if (svc_ok || (idle_q && !idle_mode)) begin
                lower_chk_q <= 1'b1;
            end
        end
    end

    // Window counter in idle timer clocks, saturating at the top
    always_ff @(posedge aclk) begin
        if (!aresetn || !wd_en) begin
            wcnt_q <= 17'h00000;
        end else if (restart) begin
            wcnt_q <= 17'h00000;
        end else if (counting && idle_timer && wcnt_q != 17'h1FFFF) begin
            wcnt_q <= wcnt_q + 17'h00001;
        end
    end

    // Fault pulse sequencer next state
    always_comb begin
        fst_d = fst_q;
        case (fst_q)
            F_IDLE: begin
                if (wd_err) begin
                    fst_d = F_DRIVE;
                end
            end
            F_DRIVE: begin
                // Stretch starts only once the pin is really low
                if (pin_low) begin
                    fst_d = F_HOLD;
                end
            end
            F_HOLD: begin
                if (hold_q == FAULT_HOLD_CYC - 6'h01) begin
                    fst_d = F_RELEASE;
                end
            end
            F_RELEASE: begin
                if (wd_fault_pin_in) begin
                    fst_d = F_IDLE;
                end
            end
            default: begin
                fst_d = F_IDLE;
            end
        endcase
    end

    // Fault sequencer state and stretch counter
    always_ff @(posedge aclk) begin
        if (!aresetn || !wd_en) begin
            fst_q  <= F_IDLE;
            hold_q <= 6'h00;
        end else begin
            fst_q <= fst_d;
            if (fst_q == F_HOLD) begin
                hold_q <= hold_q + 6'h01;
            end else begin
                hold_q <= 6'h00;
            end
        end
    end

    // Instruction clock gap measurement, saturating
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gap_q <= 24'h000000;
        end else if (instr_tick) begin
            gap_q <= 24'h000000;
        end else if (gap_q != CM_LIM) begin
            gap_q <= gap_q + 24'h000001;
        end
    end

    assign cm_slow = (gap_q == CM_LIM);

    // Monitor drive: on while slow, then stretched after recovery
    always_comb begin
        cm_drv_d = cm_drv_q;
        if (!wd_en || !cm_en_q) begin
            cm_drv_d = 1'b0;
        end else if (cm_slow) begin
            cm_drv_d = 1'b1;
        end else if (cm_hold_q == FAULT_HOLD_CYC - 6'h01) begin
            cm_drv_d = 1'b0;
        end
    end

    // Monitor state; not gated by halt or idle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cm_drv_q  <= 1'b0;
            cm_hold_q <= 6'h00;
        end else begin
            cm_drv_q <= cm_drv_d;
            if (cm_drv_q && !cm_slow) begin
                cm_hold_q <= cm_hold_q + 6'h01;
            end else begin
                cm_hold_q <= 6'h00;
            end
        end
    end

    // Pin drive: only low or released, never driven high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wd_fault_pin_out_q <= 1'b0;
            wd_fault_pin_oe_q  <= 1'b0;
        end else begin
            wd_fault_pin_out_q <= 1'b0;
            wd_fault_pin_oe_q  <= wd_en & ((fst_d == F_DRIVE) | (fst_d == F_HOLD)
                                           | cm_drv_d);
        end
    end

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_key_reads_zero: assert property (
        rvalid_q && rd_svc_q |-> rdata_q[5:1] == 5'h00)
        else $error("service key visible on read");

    a_cfg_after_reset: assert property (
        !first_q |-> win_q == 2'h3 && cm_en_q)
        else $error("reset window or monitor wrong");

    a_cfg_locked: assert property (
        first_q ##1 first_q |-> $stable(win_q) && $stable(cm_en_q))
        else $error("locked choice changed");

    a_bad_key_err: assert property (
        svc_wr && wd_en && !busy && wdata_q.key != 5'h0C |=> fst_q == F_DRIVE)
        else $error("bad key not flagged");

    a_early_err: assert property (
        svc_wr && wd_en && !busy && first_q && all_ok && lower_chk_q && !boot_q
        && wcnt_q < 17'd2048 |=> fst_q == F_DRIVE)
        else $error("early service not flagged");

    a_upper_timeout: assert property (
        counting && wcnt_q >= (17'h02000 << win_q) |=> fst_q == F_DRIVE)
        else $error("timeout not flagged");

    a_stretch_len: assert property (
        disable iff (!aresetn || wd_option_n)
        fst_q == F_DRIVE && pin_low |=> fst_q == F_HOLD [*8] ##17 fst_q == F_RELEASE)
        else $error("fault stretch not 24 cycles");

    a_ignore_busy: assert property (
        svc_wr && wd_en && (fst_q == F_DRIVE || fst_q == F_HOLD) && !hw_svc
        |=> wcnt_q == $past(wcnt_q))
        else $error("service honoured during fault");

    a_cm_drives: assert property (
        wd_en && cm_en_q && cm_slow |=> wd_fault_pin_oe_q && !wd_fault_pin_out_q)
        else $error("slow clock not driving pin");

    c_valid_svc:  cover property (svc_ok && first_q);
    c_timeout:    cover property (timeout);
    c_cm_fault:   cover property ($rose(cm_drv_q));
    c_boot_early: cover property (svc_ok && !lower_chk_q && wcnt_q < LOWER_LIMIT);

endmodule

/* File: verification/fault_pin_partner.sv */
// External reset circuit sitting on the open-drain fault pin
`timescale 1ns/1ps
module fault_pin_partner (
    // Pin driver from the watchdog
    input  wire logic oe,
    input  wire logic drv,
    // Resolved pin level seen by everyone
    output logic      pin_level
);
    // Weak pull-up holds the line high unless the watchdog sinks it
    // The low level is seen at once, so the stretch starts right away
    assign pin_level = (oe && !drv) ? 1'b0 : 1'b1;
endmodule

/* File: verification/windowed_watchdog_clock_monitor_tb.sv */
// Self-checking bench for the windowed watchdog with clock monitor
`timescale 1ns/1ps
module windowed_watchdog_clock_monitor_tb;
    import wdog_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0;           // Clock and reset
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00; // Addresses
    logic [31:0] wdata = 32'h0;                  // Write data
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0]  bresp_q, rresp_q;               // Responses
    logic [31:0] rdata_q;                        // Read data
    logic idle_timer = 1'b0, instr_tick = 1'b0;  // Time bases
    logic tick_en = 1'b1, boot_exit = 1'b0;      // Clock gate, boot pulse
    logic wd_opt_n = 1'b0, idle_md = 1'b0;       // Option bit, idle mode
    logic [3:0] tdiv = 4'h0;                     // Instruction clock divider
    logic oe, drv, pin;                          // Fault pin
    int mismatches = 0, compares = 0;
    int n, i;
    logic [1:0]  r;
    logic [31:0] d;
    logic [7:0]  bad [3] = '{8'hD8, 8'h50, 8'h59}; // Window, key, monitor on
    // Period 10 ns
    always #5 aclk = ~aclk;
    // Idle timer every other cycle; instruction clock every ten when enabled
    always @(posedge aclk) begin
        idle_timer <= ~idle_timer;
        tdiv       <= (tdiv == 4'h9) ? 4'h0 : tdiv + 4'h1;
        instr_tick <= tick_en && (tdiv == 4'h0);
    end
    // Short monitor threshold keeps the run brief
    windowed_watchdog #(.CM_REJECT(50)) u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready_q(awready_q),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready_q(wready_q),
        .bresp_q(bresp_q), .bvalid_q(bvalid_q), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready_q(arready_q),
        .rdata_q(rdata_q), .rresp_q(rresp_q), .rvalid_q(rvalid_q), .rready(rready),
        .wd_option_n(wd_opt_n), .idle_timer(idle_timer), .instr_tick(instr_tick),
        .halt_mode(1'b0), .idle_mode(idle_md), .boot_enter(1'b0), .boot_exit(boot_exit),
        .wd_fault_pin_in(pin), .wd_fault_pin_out_q(drv), .wd_fault_pin_oe_q(oe)
    );
    // Far side of the fault pin
    fault_pin_partner u_pin (.oe(oe), .drv(drv), .pin_level(pin));
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // AXI4-Lite write; each channel released once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic done;
        done = 1'b0;
        // One edge first, so a release by the previous call is not overwritten
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready_q) awvalid <= 1'b0;
            if (wvalid && wready_q) wvalid <= 1'b0;
            if (bready && bvalid_q) begin
                rs = bresp_q;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    // AXI4-Lite read
    task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready_q) arvalid <= 1'b0;
            if (rready && rvalid_q) begin
                v = rdata_q;
                rs = rresp_q;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    // Wait for the pin enable to reach a level; -1 when the limit runs out
    task automatic wait_oe(input logic v, input int lim, output int cnt);
        cnt = 0;
        while (oe !== v && cnt < lim) begin
            @(posedge aclk);
            cnt++;
        end
        if (oe !== v) cnt = -1;
    endtask
    // One fault pulse: raised promptly, stretched 16 to 32 cycles after low
    // With svc set, a matching service is written while the pulse is held
    task automatic expect_pulse(input int lim, input logic svc);
        wait_oe(1'b1, lim, n);
        chk("fault_raised", n >= 0, 1);
        if (svc) begin
            axw(SVC_ADDR, 32'h58, r);
        end
        wait_oe(1'b0, 200, n);
        chk("fault_hold", n >= 16 && n <= 34, 1);
        repeat (3) @(posedge aclk);
    endtask
    // Ends the run with a verdict
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Hang guard, well beyond the 16k window the run uses
    initial begin
        repeat (90000) @(posedge aclk);
        mismatches++;
        conclude();
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axr(SVC_ADDR, d, r);
        chk("svc_reset", d, 32'h000000C1);
        axr(8'h08, d, r);
        chk("rd_unmapped", r, RESP_DECERR);
        axw(8'h08, 32'h0, r);
        chk("wr_unmapped", r, RESP_DECERR);
        // Option bit set: neither detector may touch the pin
        wd_opt_n <= 1'b1;
        tick_en  <= 1'b0;
        wait_oe(1'b1, 100, n);
        chk("opt_off", n, -1);
        wd_opt_n <= 1'b0;
        // Clock stays stopped: monitor drives the shared pin
        wait_oe(1'b1, 80, n);
        chk("cm_stop", n >= 0, 1);
        tick_en <= 1'b1;
        wait_oe(1'b0, 80, n);
        chk("cm_release", n >= 16 && n <= 50, 1);
        repeat (3) @(posedge aclk);
        // First keyed service picks 16k window and turns the monitor off
        axw(SVC_ADDR, 32'h58, r);
        chk("svc_first", r, RESP_OKAY);
        axr(SVC_ADDR, d, r);
        chk("svc_locked", d, 32'h00000040);
        axr(STAT_ADDR, d, r);
        chk("stat_first", d[4:0], 5'h09);
        tick_en <= 1'b0;
        wait_oe(1'b1, 200, n);
        chk("cm_off", n, -1);
        tick_en <= 1'b1;
        // Second service far inside the lower limit
        axw(SVC_ADDR, 32'h58, r);
        expect_pulse(10, 1'b1);
        // Matching service after the lower limit is quiet
        repeat (4300) @(posedge aclk);
        axw(SVC_ADDR, 32'h58, r);
        wait_oe(1'b1, 30, n);
        chk("svc_valid", n, -1);
        // Each field mismatch faults
        for (i = 0; i < 3; i++) begin
            repeat (4300) @(posedge aclk);
            axw(SVC_ADDR, {24'h0, bad[i]}, r);
            expect_pulse(10, 1'b0);
        end
        // Boot return disarms the lower check
        repeat (4300) @(posedge aclk);
        axw(SVC_ADDR, 32'h58, r);
        boot_exit <= 1'b1;
        @(posedge aclk);
        boot_exit <= 1'b0;
        repeat (50) @(posedge aclk);
        axw(SVC_ADDR, 32'h58, r);
        wait_oe(1'b1, 30, n);
        chk("boot_early", n, -1);
        // Leaving idle is a hardware service, so a prompt write is early
        repeat (4300) @(posedge aclk);
        idle_md <= 1'b1;
        repeat (100) @(posedge aclk);
        idle_md <= 1'b0;
        repeat (4) @(posedge aclk);
        axw(SVC_ADDR, 32'h58, r);
        expect_pulse(10, 1'b0);
        // No further service: upper limit of 16k idle clocks expires
        wait_oe(1'b1, 32000, n);
        chk("upper_quiet", n, -1);
        expect_pulse(1500, 1'b0);
        conclude();
    end
endmodule
